// ==== hw/ospc_timer.sv ====
// Purpose: Timer channel with trigger capture and compare-driven toggle output
// Assumes: trigger_input is asynchronous; bus master obeys one-cycle strobes
// Notes: All outputs are registered; interrupt outputs are one-cycle pulses
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
module ospc_timer
	import ospc_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire ospc_bus_t busReq,
	output logic [DW-1:0] rdata,
	input wire logic trigger_input,
	output logic pulse_output_pin,
	output logic capture_zero_irq,
	output logic match_irq
);
	logic syncA, syncB, syncC, trigLvl;
	logic next_trigLvl, trigRise;
	logic [PW-1:0] presc, next_presc;
	logic [CW-1:0] up_counter, next_up_counter;
	logic [CW-1:0] capture_reg_zero, next_capture_reg_zero;
	logic [CW-1:0] compare_reg_zero, next_compare_reg_zero;
	logic [CW-1:0] compare_reg_one, next_compare_reg_one;
	logic channel_enable_reg, next_channel_enable_reg;
	logic [1:0] run_control, next_run_control;
	ospc_mode_t timer_mode_reg, next_timer_mode_reg;
	ospc_ffcr_t flipflop_control, next_flipflop_control;
	ospc_mask_t irq_mask_reg, next_irq_mask_reg;
	logic toggle_flipflop, next_toggle_flipflop;
	logic next_capIrq, next_matchIrq;
	logic [DW-1:0] next_rdata;
	logic counting, prescRun, tapHit, tick;
	logic matchZero, matchOne, overflow, capEv, toggle;
	logic ffWrite;
	ospc_ffcr_t ffIn;
	logic [CW-1:0] ucInc;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	// Trigger synchroniser and glitch filter
	always_comb begin
		next_trigLvl = trigLvl;
		if (syncB == syncC) begin
			next_trigLvl = syncB;
		end
		trigRise = (syncB == syncC) && syncB && !trigLvl;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			syncA <= 1'b0;
			syncB <= 1'b0;
			syncC <= 1'b0;
			trigLvl <= 1'b0;
		end else begin
			syncA <= trigger_input;
			syncB <= syncA;
			syncC <= syncB;
			trigLvl <= next_trigLvl;
		end
	end

	// Prescaler, count tick and event detection
	always_comb begin
		prescRun = channel_enable_reg && run_control[1];
		counting = prescRun && run_control[0];
		next_presc = prescRun ? PW'(presc + 5'h01) : 5'h00;
		case (timer_mode_reg.clkSel)
			CLK_EXT: tapHit = trigRise;
			CLK_T1: tapHit = (presc & TAP_T1) == TAP_T1;
			CLK_T4: tapHit = (presc & TAP_T4) == TAP_T4;
			CLK_T16: tapHit = (presc & TAP_T16) == TAP_T16;
			default: tapHit = 1'b0;
		endcase
		tick = counting && tapHit;
		ucInc = CW'(up_counter + CNT_ONE);
		matchZero = tick && (ucInc == compare_reg_zero);
		matchOne = tick && (ucInc == compare_reg_one);
		overflow = tick && (up_counter == CNT_MAX);
		capEv = channel_enable_reg && (timer_mode_reg.capMode == CAPM_RISE) && trigRise;
		next_up_counter = up_counter;
		if (!counting) begin
			next_up_counter = CNT_RST;
		end else if (tick) begin
			next_up_counter = ucInc;
		end
		next_capture_reg_zero = capEv ? up_counter : capture_reg_zero;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			presc <= 5'h00;
			up_counter <= CNT_RST;
			capture_reg_zero <= CNT_RST;
		end else begin
			presc <= next_presc;
			up_counter <= next_up_counter;
			capture_reg_zero <= next_capture_reg_zero;
		end
	end

	// Counter and capture checks
	count_step_a: assert property (tick |=> up_counter == CW'($past(up_counter) + CNT_ONE))
		else $error("counter did not step on tick");
	count_stop_a: assert property (!counting |=> up_counter == CNT_RST)
		else $error("counter not cleared while stopped");
	counter_wrap_a: assert property (overflow |=> up_counter == CNT_RST)
		else $error("counter did not wrap to zero");
	capture_load_a: assert property (capEv |=> capture_reg_zero == $past(up_counter))
		else $error("capture missed counter value");
	capture_hold_a: assert property (!capEv |=> $stable(capture_reg_zero))
		else $error("capture changed without edge");
	cap_mode_a: assert property (trigRise && timer_mode_reg.capMode != CAPM_RISE
		|=> $stable(capture_reg_zero))
		else $error("capture taken in wrong mode");
	enable_gate_a: assert property (!channel_enable_reg |-> !capEv && !tick)
		else $error("channel active while disabled");
	presc_clear_a: assert property (!prescRun |=> presc == 5'h00)
		else $error("prescaler not held while stopped");
	count_hold_a: assert property (counting && !tick |=> $stable(up_counter))
		else $error("counter moved without tick");

	// Toggle flip-flop and interrupt pulses
	always_comb begin
		ffIn = ospc_ffcr_t'(busReq.wdata[4:0]);
		ffWrite = busReq.wr && (busReq.addr == OFS_FFCTL);
		toggle = (matchZero && flipflop_control.m0Tog)
			^ (matchOne && flipflop_control.m1Tog)
			^ (capEv && flipflop_control.capTog);
		next_toggle_flipflop = toggle_flipflop ^ toggle;
		// A set or clear written in the same cycle wins over any inversion
		if (ffWrite && ffIn.ffCtl == FF_CLR) begin
			next_toggle_flipflop = 1'b0;
		end else if (ffWrite && ffIn.ffCtl == FF_SET) begin
			next_toggle_flipflop = 1'b1;
		end
		next_capIrq = capEv && irq_mask_reg.capIrqEn;
		next_matchIrq = (matchZero && !irq_mask_reg.m0Mask)
			|| (matchOne && !irq_mask_reg.m1Mask)
			|| (overflow && !irq_mask_reg.ovfMask);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			toggle_flipflop <= 1'b0;
			pulse_output_pin <= 1'b0;
			capture_zero_irq <= 1'b0;
			match_irq <= 1'b0;
		end else begin
			toggle_flipflop <= next_toggle_flipflop;
			pulse_output_pin <= next_toggle_flipflop;
			capture_zero_irq <= next_capIrq;
			match_irq <= next_matchIrq;
		end
	end

	sequence sLoneMatchZero;
		matchZero && flipflop_control.m0Tog && !(matchOne && flipflop_control.m1Tog)
			&& !(capEv && flipflop_control.capTog) && !ffWrite;
	endsequence
	sequence sLoneMatchOne;
		matchOne && flipflop_control.m1Tog && !(matchZero && flipflop_control.m0Tog)
			&& !(capEv && flipflop_control.capTog) && !ffWrite;
	endsequence
	sequence sCaptureToggle;
		capEv && flipflop_control.capTog && !matchZero && !matchOne && !ffWrite;
	endsequence
	sequence sFfClear;
		ffWrite && ffIn.ffCtl == FF_CLR;
	endsequence
	sequence sFfSet;
		ffWrite && ffIn.ffCtl == FF_SET;
	endsequence

	// Flip-flop and interrupt checks
	match_toggle_a: assert property ((sLoneMatchZero or sLoneMatchOne)
		|=> toggle_flipflop != $past(toggle_flipflop)
			&& pulse_output_pin != $past(pulse_output_pin))
		else $error("match did not invert output");
	nodelay_toggle_a: assert property (sCaptureToggle
		|=> toggle_flipflop != $past(toggle_flipflop))
		else $error("capture did not invert output");
	ff_clear_a: assert property (sFfClear |=> !toggle_flipflop && !pulse_output_pin)
		else $error("flip-flop not cleared");
	ff_set_a: assert property (sFfSet |=> toggle_flipflop && pulse_output_pin)
		else $error("flip-flop not set");
	toggle_hold_a: assert property (!toggle && !ffWrite |=> $stable(toggle_flipflop))
		else $error("flip-flop moved without trigger");
	cap_irq_a: assert property (capEv && irq_mask_reg.capIrqEn |=> capture_zero_irq ##1 1'b1)
		else $error("capture interrupt missing");
	irq_mask_a: assert property (matchZero && irq_mask_reg.m0Mask && !matchOne && !overflow
		|=> !match_irq)
		else $error("masked match raised interrupt");
	irq_one_a: assert property (matchOne && !irq_mask_reg.m1Mask |=> match_irq)
		else $error("compare-one interrupt missing");
	irq_zero_a: assert property (matchZero && !irq_mask_reg.m0Mask |=> match_irq)
		else $error("compare-zero interrupt missing");
	ovf_irq_a: assert property (overflow && !irq_mask_reg.ovfMask |=> match_irq)
		else $error("overflow interrupt missing");
	match_quiet_a: assert property (!matchZero && !matchOne && !overflow |=> !match_irq)
		else $error("match interrupt without match");
	cap_quiet_a: assert property (!(capEv && irq_mask_reg.capIrqEn) |=> !capture_zero_irq)
		else $error("capture interrupt without capture");

	// Register file writes
	always_comb begin
		next_channel_enable_reg = channel_enable_reg;
		next_run_control = run_control;
		next_timer_mode_reg = timer_mode_reg;
		next_flipflop_control = flipflop_control;
		next_irq_mask_reg = irq_mask_reg;
		next_compare_reg_zero = compare_reg_zero;
		next_compare_reg_one = compare_reg_one;
		if (busReq.wr) begin
			case (busReq.addr)
				OFS_ENABLE: next_channel_enable_reg = busReq.wdata[EN_BIT];
				OFS_RUN: next_run_control = {busReq.wdata[RUN_PRE_BIT], busReq.wdata[RUN_CNT_BIT]};
				OFS_MODE: next_timer_mode_reg = ospc_mode_t'(busReq.wdata[4:0]);
				OFS_FFCTL: begin
					next_flipflop_control = ffIn;
					next_flipflop_control.ffCtl = FF_KEEP;
				end
				OFS_MASK: next_irq_mask_reg = ospc_mask_t'(busReq.wdata[3:0]);
				OFS_CMP0: next_compare_reg_zero = busReq.wdata[CW-1:0];
				OFS_CMP1: next_compare_reg_one = busReq.wdata[CW-1:0];
				default: next_channel_enable_reg = channel_enable_reg;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			channel_enable_reg <= 1'b0;
			run_control <= 2'h0;
			timer_mode_reg <= ospc_mode_t'(5'h00);
			flipflop_control <= ospc_ffcr_t'({3'h0, FF_KEEP});
			irq_mask_reg <= ospc_mask_t'(MASK_RST);
			compare_reg_zero <= CNT_RST;
			compare_reg_one <= CNT_RST;
		end else begin
			channel_enable_reg <= next_channel_enable_reg;
			run_control <= next_run_control;
			timer_mode_reg <= next_timer_mode_reg;
			flipflop_control <= next_flipflop_control;
			irq_mask_reg <= next_irq_mask_reg;
			compare_reg_zero <= next_compare_reg_zero;
			compare_reg_one <= next_compare_reg_one;
		end
	end

	// Register port checks
	trig_disable_a: assert property ((sFfClear and (ffIn[4:2] == 3'h0)) |=>
		!flipflop_control.m0Tog && !flipflop_control.m1Tog && !flipflop_control.capTog)
		else $error("toggle triggers not disabled");
	ffctl_load_a: assert property (ffWrite |=>
		{flipflop_control.capTog, flipflop_control.m1Tog, flipflop_control.m0Tog}
			== 3'($past(busReq.wdata) >> 2))
		else $error("toggle selection not loaded");
	mask_write_a: assert property (busReq.wr && busReq.addr == OFS_MASK
		|=> irq_mask_reg == ospc_mask_t'(4'($past(busReq.wdata))))
		else $error("mask write lost");
	cmp0_write_a: assert property (busReq.wr && busReq.addr == OFS_CMP0
		|=> compare_reg_zero == CW'($past(busReq.wdata)))
		else $error("compare zero write lost");
	cmp1_write_a: assert property (busReq.wr && busReq.addr == OFS_CMP1
		|=> compare_reg_one == CW'($past(busReq.wdata)))
		else $error("compare one write lost");
	run_stop_a: assert property (busReq.wr && busReq.addr == OFS_RUN
		&& !busReq.wdata[RUN_CNT_BIT] |=> !counting)
		else $error("run clear did not stop counter");

	// Read port: data stand only in the cycle after the strobe
	always_comb begin
		next_rdata = '0;
		if (busReq.rd) begin
			case (busReq.addr)
				OFS_ENABLE: next_rdata[EN_BIT] = channel_enable_reg;
				OFS_RUN: begin
					next_rdata[RUN_CNT_BIT] = run_control[0];
					next_rdata[RUN_PRE_BIT] = run_control[1];
				end
				OFS_MODE: next_rdata[4:0] = timer_mode_reg;
				OFS_FFCTL: next_rdata[4:0] = flipflop_control;
				OFS_MASK: next_rdata[3:0] = irq_mask_reg;
				OFS_COUNT: next_rdata[CW-1:0] = up_counter;
				OFS_CMP0: next_rdata[CW-1:0] = compare_reg_zero;
				OFS_CMP1: next_rdata[CW-1:0] = compare_reg_one;
				OFS_CAP0: next_rdata[CW-1:0] = capture_reg_zero;
				OFS_STATUS: next_rdata[1:0] = {counting, toggle_flipflop};
				default: next_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= '0;
		end else begin
			rdata <= next_rdata;
		end
	end
endmodule

// ==== hw/ospc_pkg.sv ====
// Purpose: Constants and types for the one-shot capture pulse timer channel
// Assumes: One clock, plain register port, 32-bit data, byte addresses
// Notes: Register offsets and bit positions are local choices of this block
package ospc_pkg;
	localparam int AW = 8;
	localparam int DW = 32;
	localparam int CW = 16;
	localparam int PW = 5;
	localparam logic [AW-1:0] OFS_ENABLE = 8'h00;
	localparam logic [AW-1:0] OFS_RUN = 8'h04;
	localparam logic [AW-1:0] OFS_MODE = 8'h08;
	localparam logic [AW-1:0] OFS_FFCTL = 8'h0c;
	localparam logic [AW-1:0] OFS_MASK = 8'h10;
	localparam logic [AW-1:0] OFS_COUNT = 8'h14;
	localparam logic [AW-1:0] OFS_CMP0 = 8'h18;
	localparam logic [AW-1:0] OFS_CMP1 = 8'h1c;
	localparam logic [AW-1:0] OFS_CAP0 = 8'h20;
	localparam logic [AW-1:0] OFS_STATUS = 8'h24;
	localparam int EN_BIT = 7;
	localparam int RUN_CNT_BIT = 0;
	localparam int RUN_PRE_BIT = 2;
	localparam int MOD_CLK_LSB = 0;
	localparam int MOD_CAP_LSB = 3;
	localparam logic [1:0] CLK_EXT = 2'h0;
	localparam logic [1:0] CLK_T1 = 2'h1;
	localparam logic [1:0] CLK_T4 = 2'h2;
	localparam logic [1:0] CLK_T16 = 2'h3;
	localparam logic [1:0] CAPM_RISE = 2'h1;
	localparam logic [1:0] FF_SET = 2'h1;
	localparam logic [1:0] FF_CLR = 2'h2;
	localparam logic [1:0] FF_KEEP = 2'h3;
	localparam logic [PW-1:0] TAP_T1 = 5'h01;
	localparam logic [PW-1:0] TAP_T4 = 5'h07;
	localparam logic [PW-1:0] TAP_T16 = 5'h1f;
	localparam logic [CW-1:0] CNT_MAX = 16'hffff;
	localparam logic [CW-1:0] CNT_ONE = 16'h0001;
	localparam logic [CW-1:0] CNT_RST = 16'h0000;
	localparam logic [3:0] MASK_RST = 4'h7;
	typedef struct packed {
		logic capTog;
		logic m1Tog;
		logic m0Tog;
		logic [1:0] ffCtl;
	} ospc_ffcr_t;
	typedef struct packed {
		logic capIrqEn;
		logic ovfMask;
		logic m1Mask;
		logic m0Mask;
	} ospc_mask_t;
	typedef struct packed {
		logic [1:0] capMode;
		logic reserved;
		logic [1:0] clkSel;
	} ospc_mode_t;
	typedef struct packed {
		logic [AW-1:0] addr;
		logic [DW-1:0] wdata;
		logic wr;
		logic rd;
	} ospc_bus_t;
endpackage

// ==== verification/ospc_trig_src.sv ====
// Purpose: Far-side model that drives the external trigger pin
// Assumes: Driven by the bench with a one-cycle fire request
// Notes: Each trigger stays high four cycles, then returns low
`timescale 1ns/100ps
module ospc_trig_src (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic fire,
	output logic trigger_input
);
	logic [1:0] hold;
	// Long enough that the input synchroniser never drops the edge
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			trigger_input <= 1'b0;
			hold <= 2'h0;
		end else if (fire) begin
			trigger_input <= 1'b1;
			hold <= 2'h3;
		end else if (hold != 2'h0) begin
			hold <= hold - 2'h1;
		end else begin
			trigger_input <= 1'b0;
		end
	end
endmodule

// ==== verification/testbench.sv ====
// Purpose: Self-checking bench for the one-shot capture pulse channel
// Assumes: Counter runs on clk/2 first, then on clk/8, clk/32 and the trigger pin; trigger comes from the partner model
// Notes: Reads are compared one cycle later from a queue of expectations
`timescale 1ns/100ps
module testbench
	import ospc_pkg::*;
;
	logic clk, arst_n, fire, rdSeen, pin, capIrq, mIrq;
	logic trig;
	ospc_bus_t busReq;
	logic [DW-1:0] rdata, c, n, a, d, p, rng;
	logic [32:0] expQ[$];
	int failures, nCompared, nMatch, w;
	logic [7:0] ra[9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18, 8'h1c, 8'h20, 8'h3c};
	logic [31:0] re[9] = '{32'h0, 32'h0, 32'h0, 32'h3, 32'h7, 32'h0, 32'h0, 32'h0, 32'h0};
	ospc_timer DUT (.clk(clk), .arst_n(arst_n), .busReq(busReq), .rdata(rdata),
		.trigger_input(trig), .pulse_output_pin(pin), .capture_zero_irq(capIrq),
		.match_irq(mIrq));
	ospc_trig_src src (.clk(clk), .arst_n(arst_n), .fire(fire), .trigger_input(trig));
	always #2 clk = ~clk;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		nCompared++;
		if (s !== e) begin
			failures++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic complete_run();
		$display("compared %0d failures %0d", nCompared, failures);
		if (failures == 0 && nCompared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic bus(input logic [7:0] ad, input logic [31:0] dt, input logic w1, input logic r1);
		busReq <= '{ad, dt, w1, r1};
		@(posedge clk);
		busReq <= '0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
		bus(ad, dt, 1'b1, 1'b0);
	endtask
	task automatic rd(input logic [7:0] ad, input logic [31:0] e);
		expQ.push_back({1'b0, e});
		bus(ad, 32'h0, 1'b0, 1'b1);
	endtask
	task automatic rdv(input logic [7:0] ad, output logic [31:0] v);
		expQ.push_back({1'b1, 32'h0});
		busReq <= '{ad, 32'h0, 1'b0, 1'b1};
		@(posedge clk);
		busReq <= '0;
		@(negedge clk);
		v = rdata;
		@(posedge clk);
	endtask
	task automatic wait_irq();
		for (int k = 0; k < 200 && capIrq !== 1'b1; k++) @(negedge clk);
		if (capIrq !== 1'b1) failures++;
		@(posedge clk);
	endtask
	task automatic pin_is(input logic e);
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk({31'h0, pin}, {31'h0, e});
		@(posedge clk);
	endtask
	task automatic trigger();
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
	endtask
	always @(posedge clk) rdSeen <= busReq.rd;
	always @(posedge clk) if (mIrq === 1'b1) nMatch++;
	always @(negedge clk) begin
		logic [32:0] e;
		if (rdSeen === 1'b1) begin
			e = expQ.pop_front();
			if (!e[32]) chk(rdata, e[31:0]);
		end
	end
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		complete_run();
	end
	initial begin
		clk = 0;
		arst_n = 0;
		busReq = '0;
		fire = 0;
		rdSeen = 0;
		rng = 32'd35;
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 9; i++) rd(ra[i], re[i]);
		wr(OFS_ENABLE, 32'h80);
		wr(OFS_MODE, 32'h09);
		wr(OFS_FFCTL, 32'h02);
		wr(OFS_MASK, 32'h0f);
		wr(OFS_RUN, 32'h05);
		rdv(OFS_COUNT, a);
		repeat (18) @(posedge clk);
		rdv(OFS_COUNT, n);
		chk(n - a, 32'd10);
		rng = xs(rng);
		d = 32'd12 + rng[4:0];
		rng = xs(rng);
		p = 32'd8 + rng[3:0];
		trigger();
		wait_irq();
		rdv(OFS_CAP0, c);
		rdv(OFS_COUNT, n);
		chk({31'h0, (n - c) < 8}, 32'h1);
		wr(OFS_CMP0, c + d);
		wr(OFS_CMP1, c + d + p);
		wr(OFS_FFCTL, 32'h0f);
		wr(OFS_MASK, 32'h0d);
		a = nMatch;
		w = 0;
		for (int k = 0; k < 400 && pin !== 1'b1; k++) @(negedge clk);
		for (int k = 0; k < 400 && pin === 1'b1; k++) begin
			@(negedge clk);
			w++;
		end
		repeat (4) @(posedge clk);
		chk(w, 2 * p);
		chk(nMatch - a, 32'h1);
		wr(OFS_FFCTL, 32'h03);
		rd(OFS_FFCTL, 32'h3);
		rd(OFS_CAP0, c);
		wr(OFS_FFCTL, 32'h13);
		trigger();
		wait_irq();
		pin_is(1'b1);
		rdv(OFS_CAP0, c);
		wr(OFS_CMP1, c + p);
		wr(OFS_FFCTL, 32'h0b);
		repeat (2 * p + 4) @(posedge clk);
		pin_is(1'b0);
		wr(OFS_FFCTL, 32'h01);
		pin_is(1'b1);
		wr(OFS_FFCTL, 32'h02);
		pin_is(1'b0);
		wr(OFS_RUN, 32'h00);
		rd(OFS_COUNT, 32'h0);
		repeat (10) @(posedge clk);
		rd(OFS_COUNT, 32'h0);
		wr(OFS_MODE, 32'h0a);
		wr(OFS_RUN, 32'h05);
		rdv(OFS_COUNT, a);
		repeat (30) @(posedge clk);
		rdv(OFS_COUNT, n);
		chk(n - a, 32'd4);
		wr(OFS_MODE, 32'h0b);
		rdv(OFS_COUNT, a);
		repeat (62) @(posedge clk);
		rdv(OFS_COUNT, n);
		chk(n - a, 32'd2);
		wr(OFS_MODE, 32'h00);
		rdv(OFS_COUNT, a);
		trigger();
		repeat (8) @(posedge clk);
		rdv(OFS_COUNT, n);
		chk(n - a, 32'd1);
		rd(OFS_CAP0, c);
		repeat (3) @(posedge clk);
		complete_run();
	end
endmodule
